// file: verilog/panel_menu_pkg.sv
// Constants and types for the front-panel function menu controller
package panel_menu_pkg;

	// Clock and time base
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_NS = 1_000_000;
	localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
	localparam int TICK_W = 15;
	localparam int MS_W = 12;

	// Display timing in milliseconds, with flash and sweep step counts
	localparam logic [MS_W-1:0] SLOT_BLINK_MS = 12'd3000;
	localparam logic [MS_W-1:0] FLASH_MS = 12'd250;
	localparam logic [MS_W-1:0] FLICK_MS = 12'd50;
	localparam logic [MS_W-1:0] LOCKPAT_MS = 12'd1000;
	localparam logic [MS_W-1:0] SWEEP_MS = 12'd60;
	localparam logic [MS_W-1:0] FLASH_N2 = 12'd4;
	localparam logic [MS_W-1:0] SWEEP_N = 12'd16;

	// Widths
	localparam int AL_W = 16;
	localparam int PW_W = 16;
	localparam int CH_N = 16;

	// Synchronised key vector positions
	localparam int K_FN = 16;
	localparam int K_ENT = 17;
	localparam int K_CAN = 18;
	localparam int K_OTH = 19;
	localparam int KEY_W = 20;

	// Function numbers as channel key index (key 1 is index 0)
	localparam logic [3:0] FN_CLEAR = 4'h0;
	localparam logic [3:0] FN_LOCK = 4'h8;
	localparam logic [3:0] FN_PW = 4'h9;
	localparam logic [3:0] FN_QUERY = 4'ha;
	localparam logic [3:0] FN_NEW_AL = 4'hb;
	localparam logic [3:0] FN_USE_ST = 4'hc;
	localparam logic [3:0] FN_USE_DEF = 4'hd;
	localparam logic [2:0] PW_DIGITS = 3'h4;
	localparam logic [PW_W-1:0] PW_DEFAULT = 16'h0000;

	// Register map (byte addresses) and fields
	localparam logic [3:0] ADR_CTRL = 4'h0;
	localparam logic [3:0] ADR_STAT = 4'h4;
	localparam logic [3:0] ADR_ALIGN = 4'h8;
	localparam int CTRL_ELOCK = 0;
	localparam int CTRL_MGD = 1;

	// Display patterns
	localparam logic [CH_N-1:0] PAT_A = 16'haaaa;
	localparam logic [CH_N-1:0] PAT_B = 16'h5555;
	localparam logic [CH_N-1:0] SWEEP_START = 16'h8000;

	typedef enum logic [2:0] {
		IDLE, SEL, ARM, PW_IN, CUR_PW, NEW_PW
	} state_t;

	typedef enum logic [2:0] {
		EFF_NONE, EFF_FLASH2, EFF_FLICK, EFF_LOCKPAT, EFF_SWEEP,
		EFF_CHFLASH, EFF_SLOT
	} eff_t;

	typedef struct packed {
		logic use_stored;
		logic [AL_W-1:0] stored;
		logic [PW_W-1:0] pw;
	} nv_t;

	typedef struct packed {
		logic fn;
		logic enter_cancel;
		logic edit_lock;
		logic vcc_list;
		logic yellow;
		logic [CH_N-1:0] ch;
		logic [CH_N-1:0] sig_present;
		logic slot_on;
		logic [3:0] slot_digit;
	} led_t;

endpackage

// file: verilog/panel_menu.sv
// Front-panel function menu controller with Wishbone register slave
//
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
// Contract
// - Functions 1-8 on input channel keys, 9-16 on output channel keys.
// - Decode: 1 clear, 2-8 reserved, 9 lock, 10 password, 11-14 alignment.
// - Function key lights its LED, channel key selects, confirm acts.
// - Cancel or any non-channel key after function abandons the request.
// - Clear resources only when module unlocked and not managed.
// - Function 1 flashes list and active channels; clears only on confirm.
// - Password from keys 1-16, repeats allowed, last four presses kept.
// - Function 9 on controller flashes channels twice then takes password.
// - Wrong password flickers edit-lock LED, lock state unchanged.
// - Successful lock plays pattern; network stays locked until unlocked; code clears the lock on reset and does not retain it.
// - Edit-lock LED stays lit while the network is locked; code flickers it during a wrong-password flicker.
// - Lock/unlock only on controller; unlock sweeps LEDs right to left.
// - Function 10 only unlocked: old password, then new, channels flash.
// - Default password is key one four times.
// - Default alignment computed at power-up and on rate change.
// - Function 11 blinks 1 or 0 in slot display for three seconds.
// - Function 12 on unlocked controller stores new value on confirm.
// - Stored value used only after function 13 and only on controller.
// - Function 13 confirm activates stored value; cancel reverts default.
// - Activated stored value survives power cycles.
// - Function 14 on controller selects default value on confirm.
module panel_menu
	import panel_menu_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Front-panel keys and role strap
	input wire logic fn_key_i,
	input wire logic [CH_N-1:0] ch_key_i,
	input wire logic enter_key_i,
	input wire logic cancel_key_i,
	input wire logic other_key_i,
	input wire logic ctrl_role_i,
	// Network side
	input wire logic [CH_N-1:0] act_ch_i,
	input wire logic rate_change_i,
	input wire logic [AL_W-1:0] align_meas_i,
	input wire logic nv_valid_i,
	input wire nv_t nv_i,
	output nv_t nv_o,
	output logic clear_res_o,
	output logic [AL_W-1:0] align_value_o,
	// Indicators
	output led_t led_o
);

	////////////////////////////////////////////////////////////////////
	// Key synchronisers and press detection
	logic [KEY_W-1:0] key_s1_q, key_s2_q, key_s3_q;
	logic ctrl_s1_q, ctrl_q;
	logic [KEY_W-1:0] press;
	logic ch_any;
	logic [3:0] ch_idx;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			key_s1_q <= '0;
			key_s2_q <= '0;
			key_s3_q <= '0;
			ctrl_s1_q <= 1'b0;
			ctrl_q <= 1'b0;
		end else begin
			key_s1_q <= {other_key_i, cancel_key_i, enter_key_i, fn_key_i,
				ch_key_i};
			key_s2_q <= key_s1_q;
			key_s3_q <= key_s2_q;
			ctrl_s1_q <= ctrl_role_i;
			ctrl_q <= ctrl_s1_q;
		end
	end

	assign press = key_s2_q & ~key_s3_q;
	assign ch_any = |press[CH_N-1:0];

	// Lowest pressed channel; keys 0-7 input section, 8-15 output
	always_comb begin
		ch_idx = 4'h0;
		for (int i = CH_N - 1; i >= 0; i--) begin
			if (press[i]) begin
				ch_idx = 4'(i);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Millisecond tick and free flash phase
	logic [TICK_W-1:0] tick_cnt_q;
	logic tick;
	logic [MS_W-1:0] fl_ms_q;
	logic blink;

	assign tick = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_q <= '0;
		end else if (tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fl_ms_q <= '0;
		end else if (tick) begin
			if (fl_ms_q == MS_W'(2 * FLASH_MS - 1)) begin
				fl_ms_q <= '0;
			end else begin
				fl_ms_q <= fl_ms_q + 1'b1;
			end
		end
	end

	assign blink = fl_ms_q < FLASH_MS;

	////////////////////////////////////////////////////////////////////
	// Control register
	logic elock_q, managed_q;
	logic bus_req;

	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			elock_q <= 1'b0;
			managed_q <= 1'b0;
		end else if (bus_req && wb_we_i && wb_sel_i[0] &&
			wb_adr_i == ADR_CTRL) begin
			elock_q <= wb_dat_i[CTRL_ELOCK];
			managed_q <= wb_dat_i[CTRL_MGD];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Menu sequencer, password, alignment and effects
	state_t state_q;
	eff_t eff_q;
	logic [3:0] sel_q;
	logic [PW_W-1:0] buf_q;
	logic [2:0] cnt_q;
	logic [MS_W-1:0] ms_q;
	logic net_locked_q, use_st_q, init_q, clr_q, slot_dig_q;
	logic [PW_W-1:0] pw_q;
	logic [AL_W-1:0] stored_q, default_q, act_q;
	logic pw_ok, ctrl_free;

	assign pw_ok = (cnt_q == PW_DIGITS) && (buf_q == pw_q);
	assign ctrl_free = ctrl_q && !net_locked_q;

	function automatic logic [MS_W-1:0] eff_len(eff_t e);
		unique case (e)
			EFF_NONE: eff_len = '0;
			EFF_FLASH2: eff_len = MS_W'(FLASH_N2 * FLASH_MS);
			EFF_FLICK: eff_len = MS_W'(FLASH_N2 * FLASH_MS);
			EFF_LOCKPAT: eff_len = LOCKPAT_MS;
			EFF_SWEEP: eff_len = MS_W'(SWEEP_N * SWEEP_MS);
			EFF_CHFLASH: eff_len = MS_W'(FLASH_N2 * FLASH_MS);
			EFF_SLOT: eff_len = SLOT_BLINK_MS;
		endcase
	endfunction

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= IDLE;
			eff_q <= EFF_NONE;
			sel_q <= '0;
			buf_q <= '0;
			cnt_q <= '0;
			ms_q <= '0;
			net_locked_q <= 1'b0;
			pw_q <= PW_DEFAULT;
			use_st_q <= 1'b0;
			stored_q <= '0;
			act_q <= '0;
			default_q <= '0;
			init_q <= 1'b1;
			clr_q <= 1'b0;
			slot_dig_q <= 1'b0;
		end else begin
			clr_q <= 1'b0;
			if (tick) begin
				ms_q <= ms_q + 1'b1;
			end
			if (eff_q != EFF_NONE && tick && ms_q >= eff_len(eff_q)) begin
				eff_q <= EFF_NONE;
			end
			// Power-up values: measured default, retained settings
			if (init_q) begin
				init_q <= 1'b0;
				default_q <= align_meas_i;
				if (nv_valid_i) begin
					pw_q <= nv_i.pw;
					stored_q <= nv_i.stored;
					act_q <= nv_i.stored;
					use_st_q <= nv_i.use_stored;
				end
			end else if (rate_change_i) begin
				default_q <= align_meas_i;
			end
			unique case (state_q)
				IDLE: begin
					if (press[K_FN]) begin
						state_q <= SEL;
					end
				end
				SEL: begin
					if (ch_any) begin
						sel_q <= ch_idx;
						state_q <= ARM;
					end else if (|press) begin
						state_q <= IDLE;
					end
				end
				ARM: begin
					if (ch_any) begin
						sel_q <= ch_idx;
					end else if (press[K_ENT]) begin
						state_q <= IDLE;
						case (sel_q)
							FN_CLEAR: begin
								if (!elock_q && !managed_q) begin
									clr_q <= 1'b1;
								end
							end
							FN_LOCK: begin
								if (ctrl_q) begin
									state_q <= PW_IN;
									cnt_q <= '0;
									eff_q <= EFF_FLASH2;
									ms_q <= '0;
								end
							end
							FN_PW: begin
								if (!net_locked_q) begin
									state_q <= CUR_PW;
									cnt_q <= '0;
								end
							end
							FN_QUERY: begin
								slot_dig_q <= use_st_q && ctrl_q;
								eff_q <= EFF_SLOT;
								ms_q <= '0;
							end
							FN_NEW_AL: begin
								if (ctrl_free) begin
									stored_q <= align_meas_i;
								end
							end
							FN_USE_ST: begin
								if (ctrl_free) begin
									use_st_q <= 1'b1;
									act_q <= stored_q;
								end
							end
							FN_USE_DEF: begin
								if (ctrl_q) begin
									use_st_q <= 1'b0;
								end
							end
							default: begin
							end
						endcase
					end else if (|press) begin
						state_q <= IDLE;
						if (sel_q == FN_USE_ST && ctrl_free) begin
							use_st_q <= 1'b0;
						end
					end
				end
				PW_IN, CUR_PW, NEW_PW: begin
					if (ch_any) begin
						buf_q <= {buf_q[PW_W-5:0], ch_idx};
						if (cnt_q != PW_DIGITS) begin
							cnt_q <= cnt_q + 1'b1;
						end
					end else if (press[K_ENT]) begin
						state_q <= IDLE;
						ms_q <= '0;
						if (state_q == NEW_PW && cnt_q == PW_DIGITS) begin
							pw_q <= buf_q;
							eff_q <= EFF_CHFLASH;
						end else if (state_q == CUR_PW && pw_ok) begin
							state_q <= NEW_PW;
							cnt_q <= '0;
						end else if (state_q == PW_IN && pw_ok && ctrl_q) begin
							net_locked_q <= !net_locked_q;
							eff_q <= net_locked_q ? EFF_SWEEP : EFF_LOCKPAT;
						end else begin
							eff_q <= EFF_FLICK;
						end
					end else if (|press) begin
						state_q <= IDLE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Applied alignment value and outputs of retained state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			align_value_o <= '0;
		end else begin
			align_value_o <= (use_st_q && ctrl_q) ? act_q : default_q;
		end
	end

	assign nv_o = '{use_stored: use_st_q, stored: stored_q, pw: pw_q};
	assign clear_res_o = clr_q;

	////////////////////////////////////////////////////////////////////
	// Indicator drive
	led_t led_d;
	logic eblink, flick;
	logic [3:0] sweep_step;

	assign eblink = (ms_q % MS_W'(2 * FLASH_MS)) < FLASH_MS;
	assign flick = (ms_q % MS_W'(2 * FLICK_MS)) < FLICK_MS;
	assign sweep_step = 4'(ms_q / SWEEP_MS);

	always_comb begin
		led_d = '0;
		led_d.fn = (state_q == SEL) || (state_q == ARM);
		led_d.enter_cancel = blink && (state_q != IDLE) &&
			(state_q != SEL);
		led_d.edit_lock = (eff_q == EFF_FLICK) ? flick : net_locked_q;
		if (state_q == ARM && sel_q == FN_CLEAR) begin
			led_d.vcc_list = blink;
			led_d.ch = blink ? act_ch_i : '0;
		end
		led_d.yellow = blink && (state_q == ARM) &&
			(sel_q >= FN_NEW_AL) && (sel_q <= FN_USE_DEF);
		if (eff_q == EFF_FLASH2 || eff_q == EFF_CHFLASH) begin
			led_d.ch = {CH_N{eblink}};
		end
		if (eff_q == EFF_LOCKPAT) begin
			led_d.sig_present = eblink ? PAT_A : PAT_B;
		end else if (eff_q == EFF_SWEEP) begin
			led_d.sig_present = SWEEP_START >> sweep_step;
		end
		led_d.slot_on = (eff_q == EFF_SLOT) && eblink;
		led_d.slot_digit = {3'h0, slot_dig_q};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			led_o <= '0;
		end else begin
			led_o <= led_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Wishbone answer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= '0;
			if (bus_req && !wb_we_i) begin
				unique case (wb_adr_i)
					ADR_CTRL: wb_dat_o <= 32'({managed_q, elock_q});
					ADR_STAT: wb_dat_o <= 32'({state_q, ctrl_q, use_st_q,
						net_locked_q});
					ADR_ALIGN: wb_dat_o <= {stored_q, align_value_o};
					default: wb_dat_o <= '0;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	fn_led_lit_a: assert property (
		state_q == SEL |=> led_o.fn)
		else $error("function LED not lit while selecting");

	cancel_abort_a: assert property (
		(state_q == SEL || state_q == ARM) && press[K_CAN]
		|=> state_q == IDLE)
		else $error("cancel did not abandon request");

	clear_gate_a: assert property (
		clear_res_o |-> !elock_q && !managed_q && $past(sel_q == FN_CLEAR))
		else $error("resource clear while not permitted");

	wrong_pw_a: assert property (
		state_q == PW_IN && press[K_ENT] && !pw_ok
		|=> $stable(net_locked_q) && eff_q == EFF_FLICK)
		else $error("wrong password changed lock state");

	locked_led_a: assert property (
		net_locked_q && $past(net_locked_q) && eff_q != EFF_FLICK
		&& $past(eff_q) != EFF_FLICK |=> led_o.edit_lock)
		else $error("edit-lock LED dark while network locked");

	lock_on_ctrl_a: assert property (
		$changed(net_locked_q) |-> $past(ctrl_q) && $past(state_q) == PW_IN)
		else $error("lock changed away from controller");

	pw_change_a: assert property (
		$changed(pw_q) && !$past(init_q)
		|-> $past(state_q) == NEW_PW && !net_locked_q)
		else $error("password changed outside its sequence");

	stored_use_a: assert property (
		!ctrl_q ##1 !ctrl_q |=> align_value_o == $past(default_q))
		else $error("stored value applied off controller");

	reserved_nop_a: assert property (
		state_q == ARM && press[K_ENT] && sel_q > FN_CLEAR
		&& sel_q < FN_LOCK |=> state_q == IDLE && $stable(use_st_q)
		&& $stable(net_locked_q) && !clear_res_o)
		else $error("reserved function changed state");

endmodule // panel_menu

// file: tb/panel_operator.sv
// Operator model that presses front-panel keys
`timescale 1ns/10ps
module panel_operator
	import panel_menu_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Keys, high while pressed
	output logic [KEY_W-1:0] key_o
);
	initial key_o = '0;
	// Press one key, hold it, release, then pause
	task automatic press(input int k);
		@(posedge clk_i);
		key_o[k] <= 1'b1;
		repeat (4) @(posedge clk_i);
		key_o[k] <= 1'b0;
		repeat (8) @(posedge clk_i);
	endtask
endmodule // panel_operator

// file: tb/front_panel_function_menu_tb_top.sv
// Self-checking bench for the front-panel function menu
`timescale 1ns/10ps
module front_panel_function_menu_tb_top
	import panel_menu_pkg::*;
;
	logic clk_i = 0, rst_i = 1;
	logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
	logic [3:0] wb_adr_i = '0;
	logic [31:0] wb_dat_i = '0, wb_dat_o, rd, r, seed_q = 32'h1ae2ff35;
	logic ctrl_role_i = 1, rate_change_i = 0, nv_valid_i = 0, clear_res_o;
	logic [CH_N-1:0] act_ch_i = '0;
	logic [AL_W-1:0] align_meas_i = 16'h1234, align_value_o;
	logic [AL_W-1:0] def_v = 16'h1234, st_v;
	logic [15:0] pw_v;
	logic [KEY_W-1:0] key;
	nv_t nv_i = '0, nv_o, nv_s;
	led_t led_o;
	int err_count = 0, total_checks = 0, cyc_n = 0, clr_n = 0, n0;
	////////////////////////////////////////////////////////////
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (clear_res_o === 1'b1) clr_n <= clr_n + 1;
		if (cyc_n == 100000) begin
			err_count++;
			finish_test();
		end
	end
	panel_operator op_u (.clk_i(clk_i), .key_o(key));
	panel_menu #(.TICK_CYCLES(4)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.fn_key_i(key[K_FN]), .ch_key_i(key[CH_N-1:0]),
		.enter_key_i(key[K_ENT]), .cancel_key_i(key[K_CAN]),
		.other_key_i(key[K_OTH]), .ctrl_role_i(ctrl_role_i),
		.act_ch_i(act_ch_i), .rate_change_i(rate_change_i),
		.align_meas_i(align_meas_i), .nv_valid_i(nv_valid_i),
		.nv_i(nv_i), .nv_o(nv_o), .clear_res_o(clear_res_o),
		.align_value_o(align_value_o), .led_o(led_o)
	);
	////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed_q = seed_q ^ (seed_q << 13);
		seed_q = seed_q ^ (seed_q >> 17);
		seed_q = seed_q ^ (seed_q << 5);
		return seed_q;
	endfunction
	function automatic logic [AL_W-1:0] exp_al(input logic u, input logic c);
		return (u && c) ? st_v : def_v;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic st_chk(input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, ADR_STAT, 32'h0);
		chk(rd & m, e);
	endtask
	task automatic sel_fn(input int n, input int last);
		op_u.press(K_FN);
		op_u.press(n - 1);
		op_u.press(last);
	endtask
	task automatic digits(input logic [15:0] p);
		for (int i = 3; i >= 0; i--) op_u.press(int'(p[i*4 +: 4]));
		op_u.press(K_ENT);
	endtask
	task automatic wait_ms(input int ms);
		repeat (ms * 4) @(posedge clk_i);
	endtask
	task automatic lock_try(input logic [15:0] p, input logic el);
		sel_fn(9, K_ENT);
		wait_ms(1050);
		digits(p);
		chk(led_o.edit_lock, el);
		wait_ms(1050);
	endtask
	task automatic set_ctrl(input logic c);
		ctrl_role_i <= c;
		repeat (6) @(posedge clk_i);
	endtask
	task automatic finish_test();
		$display("Checks %0d, errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk(led_o === '0, 1);
		chk(nv_o.pw, 16'h0000);
		repeat (8) @(posedge clk_i);
		chk(align_value_o, exp_al(0, 1));
		r = rnd();
		def_v = r[15:0];
		align_meas_i <= def_v;
		rate_change_i <= 1'b1;
		@(posedge clk_i);
		rate_change_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(align_value_o, exp_al(0, 1));
		wb(1'b1, ADR_CTRL, 32'h3);
		wb(1'b0, ADR_CTRL, 32'h0);
		chk(rd, 32'h3);
		wb(1'b1, 4'hc, 32'hff);
		wb(1'b0, 4'hc, 32'h0);
		chk(rd, 32'h0);
		op_u.press(K_FN);
		@(negedge clk_i);
		chk(led_o.fn, 1'b1);
		st_chk(32'h38, 32'h08);
		op_u.press(K_OTH);
		st_chk(32'h38, 32'h00);
		n0 = clr_n;
		sel_fn(1, K_CAN);
		st_chk(32'h38, 32'h00);
		chk(clr_n - n0, 0);
		r = rnd();
		act_ch_i <= r[15:0];
		op_u.press(K_FN);
		op_u.press(0);
		for (int k = 0; k < 2400 && led_o.vcc_list !== 1'b1; k++)
			@(posedge clk_i);
		chk(led_o.ch, r[15:0]);
		chk({led_o.vcc_list, led_o.enter_cancel}, 2'b11);
		op_u.press(K_CAN);
		for (int i = 3; i >= 0; i--) begin
			wb(1'b1, ADR_CTRL, i);
			n0 = clr_n;
			sel_fn(1, K_ENT);
			chk(clr_n - n0, i == 0);
		end
		nv_s = nv_o;
		for (int n = 2; n <= 16; n++) begin
			if (n < 9 || n > 14) begin
				sel_fn(n, K_ENT);
				st_chk(32'h38, 32'h00);
				chk(nv_o === nv_s, 1);
			end
		end
		chk(clr_n - n0, 1);
		r = rnd();
		st_v = r[15:0];
		align_meas_i <= st_v;
		sel_fn(12, K_ENT);
		align_meas_i <= def_v;
		chk(nv_o.stored, st_v);
		chk(align_value_o, exp_al(0, 1));
		sel_fn(13, K_ENT);
		wb(1'b0, ADR_ALIGN, 32'h0);
		chk(rd, {st_v, exp_al(1, 1)});
		align_meas_i <= ~st_v;
		sel_fn(12, K_ENT);
		chk(align_value_o, exp_al(1, 1));
		align_meas_i <= st_v;
		sel_fn(12, K_ENT);
		align_meas_i <= def_v;
		sel_fn(11, K_ENT);
		@(negedge clk_i);
		chk(led_o.slot_digit, 4'h1);
		chk(led_o.slot_on, 1'b1);
		wait_ms(3050);
		chk(led_o.slot_on, 1'b0);
		set_ctrl(1'b0);
		chk(align_value_o, exp_al(1, 0));
		set_ctrl(1'b1);
		op_u.press(K_FN);
		op_u.press(12);
		for (int k = 0; k < 2400 && led_o.yellow !== 1'b1; k++)
			@(posedge clk_i);
		chk({led_o.yellow, led_o.enter_cancel}, 2'b11);
		op_u.press(K_CAN);
		chk(align_value_o, exp_al(0, 1));
		sel_fn(13, K_ENT);
		nv_i <= nv_o;
		nv_valid_i <= 1'b1;
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk(align_value_o, exp_al(1, 1));
		sel_fn(14, K_ENT);
		chk(align_value_o, exp_al(0, 1));
		set_ctrl(1'b0);
		align_meas_i <= ~st_v;
		sel_fn(12, K_ENT);
		chk(nv_o.stored, st_v);
		sel_fn(9, K_ENT);
		st_chk(32'h38, 32'h00);
		set_ctrl(1'b1);
		sel_fn(9, K_ENT);
		st_chk(32'h38, 32'h18);
		chk(led_o.ch, 16'hffff);
		wait_ms(1050);
		digits(16'h0000);
		@(negedge clk_i);
		chk(led_o.sig_present == PAT_A || led_o.sig_present == PAT_B, 1);
		wait_ms(1050);
		st_chk(32'h1, 32'h1);
		chk(led_o.edit_lock, 1'b1);
		sel_fn(10, K_ENT);
		st_chk(32'h38, 32'h00);
		lock_try(16'h1000, 1'b1);
		st_chk(32'h1, 32'h1);
		sel_fn(9, K_ENT);
		wait_ms(1050);
		op_u.press(5);
		digits(16'h0000);
		@(negedge clk_i);
		chk(led_o.sig_present, SWEEP_START);
		wait_ms(1050);
		st_chk(32'h1, 32'h0);
		sel_fn(10, K_ENT);
		digits(16'h0000);
		repeat (4) op_u.press(3);
		op_u.press(K_CAN);
		chk(nv_o.pw, 16'h0000);
		r = rnd();
		pw_v = r[15:0] | 16'h0100;
		sel_fn(10, K_ENT);
		digits(16'h0000);
		digits(pw_v);
		chk(nv_o.pw, pw_v);
		chk(led_o.ch, 16'hffff);
		wait_ms(1050);
		lock_try(16'h0000, 1'b1);
		st_chk(32'h1, 32'h0);
		lock_try(pw_v, 1'b1);
		st_chk(32'h1, 32'h1);
		lock_try(pw_v, 1'b0);
		st_chk(32'h1, 32'h0);
		finish_test();
	end
endmodule // front_panel_function_menu_tb_top
